//--- cps_top.sv
// Purpose: codec port receive/transmit flags, enables and interrupt logic behind apb
// Assumes: codec side pulses are synchronous to clk_sys; apb master holds requests
// Notes:   every access takes two access cycles; irq lags pending by one cycle
`default_nettype none

module cps_top (
    input  wire logic                          clk_sys,
    input  wire logic                          rstn,
    input  wire cps_pkg::cps_apb_req_t         apb_req,
    output var  cps_pkg::cps_apb_rsp_t         apb_rsp,
    input  wire cps_pkg::cps_rx_in_t           rx_in,
    input  wire logic                          tx_sent,
    output var  logic [cps_pkg::BYTE_W-1:0]    tx_data_q,
    output var  logic                          tx_empty_q,
    output var  logic                          irq_q
);
    import cps_pkg::*;

    // ========================================================================
    // state
    typedef struct packed {
        cps_apb_rsp_t       rsp;
        logic [BYTE_W-1:0]  rx_data;
        logic [BYTE_W-1:0]  tx_data;
        logic               rx_ie;
        logic               tx_ie;
        logic [NUM_IRQ-1:0] imask;
        logic               irq;
    } cps_top_st_t;

    cps_top_st_t st_q;
    cps_top_st_t st_d;

    logic               rx_full;
    logic               tx_empty;
    logic [NUM_IRQ-1:0] pend;

    // ========================================================================
    // bus phase decode
    logic               acc_start;
    logic               acc_done;
    logic               hit;
    logic               wr_done;
    logic               rd_done;
    logic               rx_rd_clr;
    logic               tx_wr;
    logic               ivec_wr;
    logic [NUM_IRQ-1:0] w1c;
    logic               rx_rise;
    logic               tx_rise;
    logic [DATA_W-1:0]  rd_word;

    // first access cycle answers, second (pready seen high) takes effect
    assign acc_start = apb_req.psel && apb_req.penable && !st_q.rsp.pready;
    assign acc_done  = apb_req.psel && apb_req.penable && st_q.rsp.pready;
    assign hit       = (apb_req.paddr == OFF_CTRL)  || (apb_req.paddr == OFF_RXD)
                    || (apb_req.paddr == OFF_TXD)   || (apb_req.paddr == OFF_IVEC)
                    || (apb_req.paddr == OFF_ISTAT) || (apb_req.paddr == OFF_IMASK);
    assign wr_done   = acc_done && apb_req.pwrite && hit;
    assign rd_done   = acc_done && !apb_req.pwrite && hit;

    // side effects of the access, all at the completing edge
    assign rx_rd_clr = rd_done && (apb_req.paddr == OFF_RXD);              // RL2
    assign tx_wr     = wr_done && (apb_req.paddr == OFF_TXD);              // RL6
    assign ivec_wr   = wr_done && (apb_req.paddr == OFF_IVEC);             // RL3 RL7
    assign w1c       = (wr_done && (apb_req.paddr == OFF_ISTAT))
                     ? apb_req.pwdata[NUM_IRQ-1:0] : RST_IMASK;

    // rising edges of the two status flags
    assign rx_rise   = rx_in.load && !rx_full;
    assign tx_rise   = tx_sent && !tx_empty;

    // ========================================================================
    // read mux; undefined bits read as zero
    always_comb begin
        rd_word = RST_WORD;
        unique case (apb_req.paddr)
            OFF_CTRL: begin
                rd_word[BIT_RX_FULL]  = rx_full;
                rd_word[BIT_RX_IE]    = st_q.rx_ie;
                rd_word[BIT_TX_EMPTY] = tx_empty;
                rd_word[BIT_TX_IE]    = st_q.tx_ie;
            end
            OFF_RXD:   rd_word[BYTE_W-1:0]  = st_q.rx_data;
            OFF_TXD:   rd_word[BYTE_W-1:0]  = st_q.tx_data;
            OFF_ISTAT: rd_word[NUM_IRQ-1:0] = pend;
            OFF_IMASK: rd_word[NUM_IRQ-1:0] = st_q.imask;
            default:   rd_word = RST_WORD; // vector register and holes read zero
        endcase
    end

    // ========================================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.rsp.pready  = 1'b0;
        st_d.rsp.pslverr = 1'b0;
        if (acc_start) begin
            st_d.rsp.pready  = 1'b1;
            st_d.rsp.pslverr = !hit;
            st_d.rsp.prdata  = apb_req.pwrite ? RST_WORD : rd_word;
        end
        // codec byte lands in the receive register
        if (rx_in.load) begin
            st_d.rx_data = rx_in.data; // RL1
        end
        if (tx_wr) begin
            st_d.tx_data = apb_req.pwdata[BYTE_W-1:0];
        end
        if (wr_done && (apb_req.paddr == OFF_CTRL)) begin
            st_d.rx_ie = apb_req.pwdata[BIT_RX_IE]; // RL4
            st_d.tx_ie = apb_req.pwdata[BIT_TX_IE]; // RL8
        end
        if (wr_done && (apb_req.paddr == OFF_IMASK)) begin
            st_d.imask = apb_req.pwdata[NUM_IRQ-1:0];
        end
        // registered for a clean output; costs one cycle of latency
        st_d.irq = |(pend & st_q.imask);
    end

    // synchronous clear of every state field
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q.rsp.prdata  <= RST_WORD;
            st_q.rsp.pready  <= 1'b0;
            st_q.rsp.pslverr <= 1'b0;
            st_q.rx_data     <= RST_BYTE;
            st_q.tx_data     <= RST_BYTE;
            st_q.rx_ie       <= RST_FLAG;
            st_q.tx_ie       <= RST_FLAG;
            st_q.imask       <= RST_IMASK;
            st_q.irq         <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================================================
    // status flags; the vector write is deliberately not wired to them
    cps_flag u_rx_full (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .set     (rx_in.load),   // RL1
        .clr     (rx_rd_clr),    // RL2
        .flag_q  (rx_full)
    );

    cps_flag u_tx_empty (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .set     (tx_sent),      // RL5
        .clr     (tx_wr),        // RL6
        .flag_q  (tx_empty)
    );

    // ========================================================================
    // interrupt requests
    cps_irq_bit u_irq_rx (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .rise    (rx_rise),
        .en      (st_q.rx_ie),   // RL4
        .w1c     (w1c[IRQ_RX]),
        .vec_clr (ivec_wr),      // RL3
        .pend_q  (pend[IRQ_RX])
    );

    cps_irq_bit u_irq_tx (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .rise    (tx_rise),
        .en      (st_q.tx_ie),   // RL8
        .w1c     (w1c[IRQ_TX]),
        .vec_clr (ivec_wr),      // RL7
        .pend_q  (pend[IRQ_TX])
    );

    // every output comes straight from a state flop
    assign apb_rsp    = st_q.rsp;
    assign tx_data_q  = st_q.tx_data;
    assign tx_empty_q = tx_empty;
    assign irq_q      = st_q.irq;

    // ========================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // receive flag rising while its enable is set
    sequence s_rx_enabled_rise;
        rx_rise && st_q.rx_ie;
    endsequence

    // vector write with no flag rising in the same cycle
    sequence s_vec_write_quiet;
        ivec_wr && !rx_rise && !tx_rise;
    endsequence

    // transmit flag rising while its enable is set
    sequence s_tx_enabled_rise;
        tx_rise && st_q.tx_ie;
    endsequence

    // completed write to the control register
    sequence s_ctrl_write;
        wr_done && (apb_req.paddr == OFF_CTRL);
    endsequence

    // new codec byte sets the flag and lands in the register
    a_rx_full_set: assert property (rx_in.load
                                    |=> rx_full && st_q.rx_data == $past(rx_in.data)) // RL1
        else $error("receive-full flag or data not loaded");

    // data read empties the receive flag
    a_rx_full_clr: assert property (rx_rd_clr && !rx_in.load |=> !rx_full) // RL2
        else $error("receive-full flag not cleared by data read");

    // vector write withdraws the receive request
    a_vec_rx_clear: assert property (s_vec_write_quiet |=> !pend[IRQ_RX]) // RL3
        else $error("vector write left receive request pending");

    // vector write leaves both flags alone
    a_vec_keeps_flag: assert property (ivec_wr && !rx_in.load && !tx_sent
                                       |=> $stable(rx_full) && $stable(tx_empty)) // RL3 RL7
        else $error("vector write changed a status flag");

    // receive request only while enabled
    a_rx_irq_gate: assert property ($rose(pend[IRQ_RX]) |-> $past(st_q.rx_ie)) // RL4
        else $error("receive request raised while disabled");

    // send sets the transmit flag
    a_tx_empty_set: assert property (tx_sent |=> tx_empty) // RL5
        else $error("transmit-empty flag not set after send");

    // data write empties the flag and loads the transmit register
    a_tx_empty_clr: assert property (tx_wr && !tx_sent |=> !tx_empty
                                     && tx_data_q == $past(apb_req.pwdata[BYTE_W-1:0])) // RL6
        else $error("transmit-empty flag not cleared by data write");

    // vector write withdraws the transmit request
    a_vec_tx_clear: assert property (s_vec_write_quiet |=> !pend[IRQ_TX]) // RL7
        else $error("vector write left transmit request pending");

    // transmit request only while enabled
    a_tx_irq_gate: assert property ($rose(pend[IRQ_TX]) |-> $past(st_q.tx_ie)) // RL8
        else $error("transmit request raised while disabled");

    // enabled rise latches, then reaches irq unless masked
    a_irq_latch: assert property (s_rx_enabled_rise
                                  |=> pend[IRQ_RX] ##1 irq_q || !st_q.imask[IRQ_RX]) // RL9
        else $error("enabled rise did not latch a request");

    // transmit side latches its request the same way
    a_tx_irq_latch: assert property (s_tx_enabled_rise |=> pend[IRQ_TX]) // RL9
        else $error("enabled transmit rise did not latch a request");

    // no receive request without an enabled rise
    a_rx_no_req: assert property (!(rx_rise && st_q.rx_ie) && !pend[IRQ_RX]
                                  |=> !pend[IRQ_RX]) // RL9
        else $error("receive request without enabled rise");

    // no transmit request without an enabled rise
    a_tx_no_req: assert property (!(tx_rise && st_q.tx_ie) && !pend[IRQ_TX]
                                  |=> !pend[IRQ_TX]) // RL9
        else $error("transmit request without enabled rise");

    // a load on the clearing read keeps the flag set
    a_rx_set_wins: assert property (rx_in.load && rx_rd_clr |=> rx_full) // RL1
        else $error("receive read beat a codec load");

    // a send on the clearing write keeps the flag set
    a_tx_set_wins: assert property (tx_sent && tx_wr |=> tx_empty) // RL5
        else $error("transmit write beat a send");

    // receive flag stands until its data is read
    a_rx_full_hold: assert property (rx_full && !rx_rd_clr |=> rx_full) // RL1
        else $error("receive-full flag dropped without a read");

    // transmit flag stands until new data is written
    a_tx_empty_hold: assert property (tx_empty && !tx_wr |=> tx_empty) // RL5
        else $error("transmit-empty flag dropped without a write");

    // enables follow the control write
    a_ctrl_enables: assert property (s_ctrl_write
                                     |=> st_q.rx_ie == $past(apb_req.pwdata[BIT_RX_IE])
                                     && st_q.tx_ie == $past(apb_req.pwdata[BIT_TX_IE])) // RL4 RL8
        else $error("enable bits not taken from control write");

    // enables hold without a control write
    a_enable_hold: assert property (!(wr_done && (apb_req.paddr == OFF_CTRL))
                                    |=> $stable(st_q.rx_ie) && $stable(st_q.tx_ie)) // RL4 RL8
        else $error("enable bit changed without a control write");

    // irq follows any unmasked pending request
    a_irq_level: assert property (|(pend & st_q.imask) |=> irq_q)
        else $error("irq low while unmasked request pending");

    // irq drops once nothing unmasked is pending
    a_irq_quiet: assert property (!(|(pend & st_q.imask)) |=> !irq_q)
        else $error("irq high with nothing unmasked pending");

    // one pready cycle per access
    a_apb_two_cycle: assert property (acc_start |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("apb answer not a single pready cycle");

    // pready only ever follows the first access cycle
    a_pready_cause: assert property (!acc_start |=> !apb_rsp.pready)
        else $error("pready raised without an access");

    // unmapped address answers with an error and zero data
    a_unmapped_err: assert property (acc_start && !hit
                                     |=> apb_rsp.pslverr && apb_rsp.prdata == RST_WORD)
        else $error("unmapped access not refused");

endmodule : cps_top

`default_nettype wire

//--- cps_pkg.sv
// Purpose: shared constants and carriers for the codec port status and interrupt flag block
// Assumes: one 10 MHz clock, synchronous active-low reset, apb register access
// Notes:   offsets are byte addresses on a 32-bit apb data path
// Summary of operation
// [RL1] receive-full flag, bit 7, sets when a new codec value loads; read only
// [RL2] receive-full flag clears when software reads the receive data register
// [RL3] interrupt vector write drops pending receive interrupt, receive-full flag kept
// [RL4] receive interrupt raised only while receive enable bit 6 is one
// [RL5] transmit-empty flag, bit 5, sets once transmit data went to codec; read only
// [RL6] transmit-empty flag clears when software writes a new transmit byte
// [RL7] interrupt vector write drops pending transmit interrupt, transmit-empty flag kept
// [RL8] transmit interrupt raised only while transmit enable bit 4 is one
// [RL9] request latched on flag rising edge with enable set; pending until vector write; the code also clears it on a write-one to the status register
`default_nettype none

package cps_pkg;

    // ========================================================================
    // bus geometry
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int BYTE_W  = 8;
    localparam int NUM_IRQ = 2;

    // ========================================================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00; // flags and enables
    localparam logic [ADDR_W-1:0] OFF_RXD   = 8'h04; // receive data, read clears full flag
    localparam logic [ADDR_W-1:0] OFF_TXD   = 8'h08; // transmit data, write clears empty flag
    localparam logic [ADDR_W-1:0] OFF_IVEC  = 8'h0C; // any write withdraws pending requests
    localparam logic [ADDR_W-1:0] OFF_ISTAT = 8'h10; // pending requests, write one to clear
    localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h14; // gates pending onto the irq line

    // ========================================================================
    // control register field positions
    localparam int BIT_RX_FULL  = 7;
    localparam int BIT_RX_IE    = 6;
    localparam int BIT_TX_EMPTY = 5;
    localparam int BIT_TX_IE    = 4;

    // interrupt status and mask field positions
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;

    // ========================================================================
    // reset values
    localparam logic                RST_FLAG  = 1'b0;
    localparam logic [BYTE_W-1:0]   RST_BYTE  = 8'h00;
    localparam logic [NUM_IRQ-1:0]  RST_IMASK = 2'h0;
    localparam logic [DATA_W-1:0]   RST_WORD  = 32'h0000_0000;

    // ========================================================================
    // carriers
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } cps_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } cps_apb_rsp_t;

    typedef struct packed {
        logic              load;   // one-cycle pulse: new byte from codec
        logic [BYTE_W-1:0] data;
    } cps_rx_in_t;

endpackage : cps_pkg

`default_nettype wire

//--- cps_flag.sv
// Purpose: one hardware status flag with set and clear events
// Assumes: set and clear are one-cycle pulses in the clk_sys domain
// Notes:   set wins over a clear arriving in the same cycle
`default_nettype none

module cps_flag (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic set,
    input  wire logic clr,
    output var  logic flag_q
);
    import cps_pkg::*;

    typedef struct packed {
        logic flag;
    } cps_flag_st_t;

    cps_flag_st_t st_q;
    cps_flag_st_t st_d;

    // ========================================================================
    // next state: an event landing on the clear cycle is not lost
    always_comb begin
        st_d = st_q;
        if (set) begin
            st_d.flag = 1'b1;
        end else if (clr) begin
            st_d.flag = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q.flag <= RST_FLAG;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_q = st_q.flag;

    // ========================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_flag_set_wins: assert property (set |=> flag_q)
        else $error("flag did not set after set event");
    a_flag_clr_only: assert property (clr && !set |=> !flag_q)
        else $error("flag did not clear after clear event");

endmodule : cps_flag

`default_nettype wire

//--- cps_irq_bit.sv
// Purpose: one latched interrupt request
// Assumes: rise is a one-cycle pulse on the rising edge of its status flag
// Notes:   cleared by a vector write or a write-one; a new rise with en set wins over both
`default_nettype none

module cps_irq_bit (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic rise,
    input  wire logic en,
    input  wire logic w1c,
    input  wire logic vec_clr,
    output var  logic pend_q
);
    import cps_pkg::*;

    typedef struct packed {
        logic pend;
    } cps_irq_st_t;

    cps_irq_st_t st_q;
    cps_irq_st_t st_d;

    // ========================================================================
    // latch on the edge only, so a flag that stays set does not re-raise
    always_comb begin
        st_d = st_q;
        if (rise && en) begin
            st_d.pend = 1'b1; // RL9
        end else if (w1c || vec_clr) begin
            st_d.pend = 1'b0; // RL9
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q.pend <= RST_FLAG;
        end else begin
            st_q <= st_d;
        end
    end

    assign pend_q = st_q.pend;

    // ========================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_pend_hold: assert property (pend_q && !w1c && !vec_clr |=> pend_q) // RL9
        else $error("pending request dropped without a clear");
    a_pend_gated: assert property (!en || !rise |=> !$rose(pend_q))
        else $error("request latched without enabled rise");

endmodule : cps_irq_bit

`default_nettype wire

//--- cps_codec_model.sv
// Purpose: codec stand-in that drives receive loads and transmit-done pulses
// Assumes: every change lands right after a rising clk_sys edge
// Notes:   idle data shows the inverse of the last byte, so a stale copy is never seen
`default_nettype none

module cps_codec_model (
    input  wire logic                clk_sys,
    output var  cps_pkg::cps_rx_in_t rx_in,
    output var  logic                tx_sent
);
    timeunit 1ns;
    timeprecision 1ns;
    import cps_pkg::*;

    // ========================================================================
    // idle levels at time zero
    initial begin
        rx_in   = '0;
        tx_sent = 1'b0;
    end

    // one byte from the codec, single-cycle load
    task automatic send(input logic [7:0] d);
        @(posedge clk_sys);
        rx_in <= '{load: 1'b1, data: d};
        @(posedge clk_sys);
        rx_in <= '{load: 1'b0, data: ~d};
    endtask : send

    // transmit slot finished: one-cycle pulse
    task automatic sent();
        @(posedge clk_sys);
        tx_sent <= 1'b1;
        @(posedge clk_sys);
        tx_sent <= 1'b0;
    endtask : sent

endmodule : cps_codec_model

`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench for the codec port flag and interrupt block
// Assumes: apb master waits for pready; codec stand-in drives the far side
// Notes:   a small integer model predicts flags, pending requests and irq
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cps_pkg::*;

    logic               clk_sys = 1'b0;
    logic               rstn    = 1'b0;
    cps_apb_req_t       apb_req = '0;
    cps_apb_rsp_t       apb_rsp;
    cps_rx_in_t         rx_in;
    logic               tx_sent;
    logic [BYTE_W-1:0]  tx_data_q;
    logic               tx_empty_q;
    logic               irq_q;
    int                 n_fail = 0;
    int                 samples_checked = 0;
    int                 m_rxf = 0, m_txe = 0, m_rie = 0, m_tie = 0, m_pend = 0, m_imask = 0;
    logic [7:0]         rxq[$];
    logic [31:0]        rd;
    logic               err;
    logic [7:0]         b;

    always #50 clk_sys = ~clk_sys;

    cps_top u_dut (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .apb_req    (apb_req),
        .apb_rsp    (apb_rsp),
        .rx_in      (rx_in),
        .tx_sent    (tx_sent),
        .tx_data_q  (tx_data_q),
        .tx_empty_q (tx_empty_q),
        .irq_q      (irq_q)
    );

    cps_codec_model u_codec (
        .clk_sys (clk_sys),
        .rx_in   (rx_in),
        .tx_sent (tx_sent)
    );

    // ========================================================================
    // comparison and verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // ========================================================================
    // apb transfer; starts one edge later so no signal is driven twice per step
    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk_sys);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: is_wr, paddr: a, pwdata: wd};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (apb_rsp.pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    // write and update the model; read-only bits ignored
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        case (a)
            OFF_CTRL: begin
                m_rie = d[6];
                m_tie = d[4];
            end
            OFF_TXD:   m_txe = 0;
            OFF_IVEC:  m_pend = 0;
            OFF_ISTAT: m_pend = m_pend & ~int'(d[1:0]);
            OFF_IMASK: m_imask = d[1:0];
            default: ;
        endcase
    endtask : wr

    // compare flags, pending requests and irq with the model
    task automatic chk_state();
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, (m_rxf << 7) | (m_rie << 6) | (m_txe << 5) | (m_tie << 4));
        apb(1'b0, OFF_ISTAT, 32'h0);
        chk(rd, m_pend);
        apb(1'b0, OFF_IMASK, 32'h0);
        chk(rd, m_imask);
        chk(tx_empty_q, m_txe);
        chk(irq_q, (m_pend & m_imask) != 0);
    endtask : chk_state

    // codec byte arrives; a request only on the flag's rising edge
    task automatic rx_byte();
        b = 8'($urandom);
        u_codec.send(b);
        if (m_rxf == 0 && m_rie == 1) m_pend = m_pend | 1;
        if (m_rxf == 1) void'(rxq.pop_front());
        m_rxf = 1;
        rxq.push_back(b);
    endtask : rx_byte

    task automatic rx_read();
        apb(1'b0, OFF_RXD, 32'h0);
        chk(rd, rxq.pop_front());
        m_rxf = 0;
    endtask : rx_read

    task automatic tx_done();
        u_codec.sent();
        if (m_txe == 0 && m_tie == 1) m_pend = m_pend | 2;
        m_txe = 1;
    endtask : tx_done

    // ========================================================================
    // watchdog, generous against roughly 300 expected cycles
    initial begin
        #(100 * 5000);
        n_fail++;
        stop_test();
    end

    // ========================================================================
    // main sequence
    initial begin
        void'($urandom(57));
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        chk_state();
        $display("test reset done");
        // receive with interrupt, vector write keeps the flag
        wr(OFF_IMASK, 32'h3);
        wr(OFF_CTRL, 32'h40);
        rx_byte();
        chk_state();
        wr(OFF_IVEC, 32'h0);
        chk_state();
        rx_read();
        chk_state();
        $display("test rx_irq done");
        // disabled receive, late enable, overwrite while full
        wr(OFF_CTRL, 32'h0);
        rx_byte();
        chk_state();
        wr(OFF_CTRL, 32'h40);
        rx_byte();
        chk_state();
        rx_read();
        $display("test rx_gate done");
        // transmit empty with interrupt, vector write, refill
        wr(OFF_CTRL, 32'hFF);
        tx_done();
        chk_state();
        wr(OFF_IVEC, 32'h0);
        chk_state();
        b = 8'($urandom);
        wr(OFF_TXD, {24'h0, b});
        // register loads at the completing edge; look one edge later
        @(posedge clk_sys);
        chk(tx_data_q, b);
        apb(1'b0, OFF_TXD, 32'h0);
        chk(rd, {24'h0, b});
        chk_state();
        tx_done();
        chk_state();
        $display("test tx done");
        // mask, write-one clear, unmapped address
        rx_byte();
        wr(OFF_IMASK, 32'h0);
        chk_state();
        wr(OFF_IMASK, 32'h3);
        wr(OFF_ISTAT, 32'h1);
        chk_state();
        apb(1'b1, 8'h18, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        chk_state();
        $display("test irq_ctl done");
        // set wins: codec load on the completing edge of a data read
        b = 8'($urandom);
        fork
            apb(1'b0, OFF_RXD, 32'h0);
            begin
                repeat (2) @(posedge clk_sys);
                u_codec.send(b);
            end
        join
        chk(rd, rxq.pop_front());
        rxq.push_back(b);
        chk_state();
        // set wins: send on the completing edge of a transmit write
        b = 8'($urandom);
        fork
            wr(OFF_TXD, {24'h0, b});
            begin
                repeat (2) @(posedge clk_sys);
                u_codec.sent();
            end
        join
        m_txe = 1;
        chk_state();
        // set wins: flag rise on the completing edge of a vector write
        rx_read();
        b = 8'($urandom);
        fork
            wr(OFF_IVEC, 32'h0);
            begin
                repeat (2) @(posedge clk_sys);
                u_codec.send(b);
            end
        join
        m_pend = 1;
        m_rxf = 1;
        rxq.push_back(b);
        chk_state();
        apb(1'b0, OFF_IVEC, 32'h0);
        chk(rd, 32'h0);
        $display("test set_wins done");
        stop_test();
    end

endmodule : tb

`default_nettype wire
